/* hw/timer_pwm_channels.v */
// two-channel 16-bit modulo timer with output compare, unbuffered and buffered pwm, and input capture
// assumes an 8-bit register port driven synchronously to i_clk; pins and mode inputs are synchronous
//
// Overview of operation
// - channel pin toggles at each counter wrap when toggle-on-wrap is set
// - pulse width runs from counter wrap to channel compare match
// - period set by modulo value and prescaler choice
// - pulse width set by channel compare value
// - unbuffered channel value takes effect at once; passed values give no compare
// - channel compare event raised when counter matches channel value
// - wrap event raised when counter reaches modulo value
// - buffered select on channel 0 links channels, drives channel 0 pin, starts with channel 0
// - in buffered mode last-written channel value governs from each wrap
// - in buffered mode channel 1 control unused and channel 1 pin released
// - mode pairs 0:1 unbuffered, 1:0 buffered; action 1:0 clear, 1:1 set
// - toggle-on-wrap cleared gives zero duty output
// - full-duty bit with toggle-on-wrap gives 100 percent duty
// - wrap flag set at modulo match; interrupt only when wrap enable set
// - channel flag set on capture or compare; interrupt only when enabled
// - wait mode keeps timer running, blocks register access, interrupts still wake
// - stop mode halts timer, keeps count, input capture still live, resumes after exit
// - each channel pin independently capture or compare; only channel 0 buffered
// - halt bit freezes counter, set after reset
// - counter-clear bit clears counter and prescaler, self-clears, reads zero
// - prescaler codes 0 to 6 divide by 1 to 64; code 7 stops ticks
`include "timer_pwm_consts.vh"
`timescale 1ns/1ns
`default_nettype none

module timer_pwm_channels #(
	parameter CHANNELS = 2
) (
	input  wire       i_clk,
	input  wire       i_sys_rst,
	input  wire [7:0] i_addr,
	input  wire [7:0] i_wr_data,
	input  wire       i_wr,
	input  wire       i_rd,
	input  wire       i_wait_mode,
	input  wire       i_stop_mode,
	input  wire       i_chan0_pin,
	input  wire       i_chan1_pin,
	output reg  [7:0] o_rd_data,
	output reg        o_chan0_pin,
	output reg        o_chan0_oe,
	output reg        o_chan1_pin,
	output reg        o_chan1_oe,
	output reg        o_irq
);

	// register access is refused while the cpu sits in wait mode
	wire       wr = i_wr & ~i_wait_mode;
	wire       rd = i_rd & ~i_wait_mode;

	reg        wrap_flag_q;
	reg        wrap_arm_q;
	reg        wrap_irq_enable_q;
	reg        counter_halt_q;
	reg  [2:0] divider_select_q;
	reg  [5:0] pre_q;
	reg [15:0] count_q;
	reg [15:0] period_q;
	reg        period_pend_q;
	reg  [7:0] count_low_latch_q;
	reg        count_latched_q;
	reg        active_chan_q;
	reg        last_written_q;

	wire [15:0] ctl_all;
	wire [31:0] val_all;
	wire [1:0]  pin_in = {i_chan1_pin, i_chan0_pin};
	wire [1:0]  chan_irq;

	wire pair_buffered_select = ctl_all[`CC_BUF_SEL];
	wire running = ~counter_halt_q & ~i_stop_mode;
	wire clear_wr = wr && (i_addr == `A_TIMER_CTL) && i_wr_data[`TC_CLEAR];
	// named copy so the halt reset value is picked by bit, not by a narrowing shift
	wire [7:0] ctl_rst = `RST_TIMER_CTL;

	reg tick;
	always @* begin
		case (divider_select_q)
		3'h0: tick = running;
		3'h1: tick = running & pre_q[0];
		3'h2: tick = running & (&pre_q[1:0]);
		3'h3: tick = running & (&pre_q[2:0]);
		3'h4: tick = running & (&pre_q[3:0]);
		3'h5: tick = running & (&pre_q[4:0]);
		3'h6: tick = running & (&pre_q[5:0]);
		default: tick = 1'b0;
		endcase
	end

	// modulo match once per tick; the wrap to zero lands on that same tick
	wire at_period = (count_q == period_q);
	wire wrap = tick & at_period;
	wire wrap_clr = wr && (i_addr == `A_TIMER_CTL) && wrap_arm_q && !i_wr_data[`TC_WRAP_FLAG];

	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			pre_q   <= 6'h00;
			count_q <= 16'h0000;
		end else if (clear_wr) begin
			pre_q   <= 6'h00;
			count_q <= 16'h0000;
		end else if (running) begin
			pre_q <= pre_q + 6'h01;
			if (tick) begin
				if (at_period) begin
					count_q <= 16'h0000;
				end else begin
					count_q <= count_q + 16'h0001;
				end
			end
		end
	end

	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			wrap_flag_q       <= 1'b0;
			wrap_arm_q        <= 1'b0;
			wrap_irq_enable_q <= 1'b0;
			counter_halt_q    <= ctl_rst[`TC_HALT];
			divider_select_q  <= 3'h0;
			period_q          <= `RST_PERIOD;
			period_pend_q     <= 1'b0;
		end else begin
			// a new wrap beats a clear landing in the same cycle
			wrap_flag_q <= (wrap & ~period_pend_q) | (wrap_flag_q & ~wrap_clr);
			if (rd && i_addr == `A_TIMER_CTL && wrap_flag_q) begin
				wrap_arm_q <= 1'b1;
			end else if (wr && i_addr == `A_TIMER_CTL) begin
				wrap_arm_q <= 1'b0;
			end
			if (wr && i_addr == `A_TIMER_CTL) begin
				wrap_irq_enable_q <= i_wr_data[`TC_WRAP_IE];
				counter_halt_q    <= i_wr_data[`TC_HALT];
				divider_select_q  <= i_wr_data[`TC_DIV_HI:`TC_DIV_LO];
			end
			// high byte holds off the wrap flag until the pair is complete
			if (wr && i_addr == `A_PERIOD_HIGH) begin
				period_q[15:8] <= i_wr_data;
				period_pend_q  <= 1'b1;
			end else if (wr && i_addr == `A_PERIOD_LOW) begin
				period_q[7:0]  <= i_wr_data;
				period_pend_q  <= 1'b0;
			end
		end
	end

	// buffered pair: the channel written last takes over at each wrap
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			active_chan_q  <= 1'b0;
			last_written_q <= 1'b0;
		end else if (!pair_buffered_select) begin
			active_chan_q  <= 1'b0;
			last_written_q <= 1'b0;
		end else begin
			if (wr && i_addr == `A_CHAN0_CTL + `CHAN_STRIDE + 8'h02) begin
				last_written_q <= 1'b1;
			end else if (wr && i_addr == `A_CHAN0_CTL + 8'h02) begin
				last_written_q <= 1'b0;
			end
			if (wrap) begin
				active_chan_q <= last_written_q;
			end
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < CHANNELS; gi = gi + 1) begin : g_chan
			localparam [7:0] A_CTL = `A_CHAN0_CTL + gi * `CHAN_STRIDE;
			reg  [7:0] ctl_q;
			reg [15:0] val_q;
			reg        flag_q;
			reg        arm_q;
			reg        out_q;
			reg        oe_q;
			reg        pin_prev_q;
			reg  [1:0] act;
			reg        func;
			reg        buf_sel;
			reg        used;
			reg        oc;
			reg        cap;
			reg        full;
			reg [15:0] cmp_val;
			reg        edge_hit;
			reg        match;
			reg        flag_clr;

			always @* begin
				act      = ctl_q[`CC_ACT_HI:`CC_ACT_LO];
				func     = ctl_q[`CC_FUNC_SEL];
				buf_sel  = (gi == 0) ? ctl_q[`CC_BUF_SEL] : 1'b0;
				used     = (gi == 0) | ~pair_buffered_select;
				oc       = used & (act != 2'h0) & (func | buf_sel);
				cap      = used & (act != 2'h0) & ~func & ~buf_sel;
				full     = ctl_q[`CC_FULL_DUTY] & ctl_q[`CC_TOGGLE_WRAP];
				cmp_val  = (buf_sel && active_chan_q) ? val_all[31:16] : val_q;
				match    = tick & oc & (count_q == cmp_val);
				edge_hit = cap & (pin_prev_q != pin_in[gi]) &
					((pin_in[gi] & act[0]) | (~pin_in[gi] & act[1]));
				flag_clr = wr & (i_addr == A_CTL) & arm_q & ~i_wr_data[`CC_EVENT_FLAG];
			end

			always @(posedge i_clk) begin
				if (i_sys_rst) begin
					ctl_q      <= `RST_CHAN_CTL;
					val_q      <= `RST_CHAN_VALUE;
					flag_q     <= 1'b0;
					arm_q      <= 1'b0;
					out_q      <= 1'b1;
					oe_q       <= 1'b0;
					pin_prev_q <= 1'b0;
				end else begin
					pin_prev_q <= pin_in[gi];
					// event beats a software clear in the same cycle
					flag_q <= match | edge_hit | (flag_q & ~flag_clr);
					if (rd && i_addr == A_CTL && flag_q) begin
						arm_q <= 1'b1;
					end else if (wr && i_addr == A_CTL) begin
						arm_q <= 1'b0;
					end
					if (wr && i_addr == A_CTL) begin
						ctl_q <= {1'b0, i_wr_data[6], (gi == 0) ? i_wr_data[5] : 1'b0, i_wr_data[4:0]};
					end
					if (edge_hit) begin
						val_q <= count_q;
					end else if (wr && i_addr == A_CTL + 8'h01) begin
						val_q[15:8] <= i_wr_data;
					end else if (wr && i_addr == A_CTL + 8'h02) begin
						val_q[7:0] <= i_wr_data;
					end
					oe_q <= oc;
					if (act == 2'h0) begin
						out_q <= ~func;
					end else if (oc && wrap && ctl_q[`CC_TOGGLE_WRAP]) begin
						if (full && act != `ACT_TOGGLE) begin
							out_q <= ~act[0];
						end else begin
							out_q <= ~out_q;
						end
					end else if (match && !full) begin
						// without wrap toggles the forced level already holds
						case (act)
						`ACT_TOGGLE: out_q <= ~out_q;
						`ACT_CLEAR:  out_q <= 1'b0;
						default:     out_q <= 1'b1;
						endcase
					end
				end
			end

			assign ctl_all[gi*8 +: 8]   = {flag_q, ctl_q[6:0]};
			assign val_all[gi*16 +: 16] = val_q;
			assign chan_irq[gi]         = flag_q & ctl_q[`CC_IRQ_EN] & used;
		end
	endgenerate

	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_chan0_pin <= 1'b1;
			o_chan0_oe  <= 1'b0;
			o_chan1_pin <= 1'b1;
			o_chan1_oe  <= 1'b0;
			o_irq       <= 1'b0;
		end else begin
			o_chan0_pin <= g_chan[0].out_q;
			o_chan0_oe  <= g_chan[0].oe_q;
			o_chan1_pin <= g_chan[1].out_q;
			o_chan1_oe  <= g_chan[1].oe_q;
			// stays live in wait mode so any enabled event wakes the cpu
			o_irq <= (wrap_flag_q & wrap_irq_enable_q) | (|chan_irq);
		end
	end

	// reading the high count byte freezes the low byte until it is read
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			count_low_latch_q <= 8'h00;
			count_latched_q   <= 1'b0;
			o_rd_data         <= 8'h00;
		end else begin
			if (rd && i_addr == `A_COUNT_HIGH && !count_latched_q) begin
				count_low_latch_q <= count_q[7:0];
				count_latched_q   <= 1'b1;
			end else if (rd && i_addr == `A_COUNT_LOW) begin
				count_latched_q <= 1'b0;
			end
			if (!rd) begin
				o_rd_data <= 8'h00;
			end else if (i_addr == `A_TIMER_CTL) begin
				o_rd_data <= {wrap_flag_q, wrap_irq_enable_q, counter_halt_q, 2'b00, divider_select_q};
			end else if (i_addr == `A_COUNT_HIGH) begin
				o_rd_data <= count_q[15:8];
			end else if (i_addr == `A_COUNT_LOW) begin
				o_rd_data <= count_latched_q ? count_low_latch_q : count_q[7:0];
			end else if (i_addr == `A_PERIOD_HIGH) begin
				o_rd_data <= period_q[15:8];
			end else if (i_addr == `A_PERIOD_LOW) begin
				o_rd_data <= period_q[7:0];
			end else if (i_addr == `A_CHAN0_CTL) begin
				o_rd_data <= ctl_all[7:0];
			end else if (i_addr == `A_CHAN0_CTL + 8'h01) begin
				o_rd_data <= val_all[15:8];
			end else if (i_addr == `A_CHAN0_CTL + 8'h02) begin
				o_rd_data <= val_all[7:0];
			end else if (i_addr == `A_CHAN0_CTL + `CHAN_STRIDE) begin
				o_rd_data <= ctl_all[15:8];
			end else if (i_addr == `A_CHAN0_CTL + `CHAN_STRIDE + 8'h01) begin
				o_rd_data <= val_all[31:24];
			end else if (i_addr == `A_CHAN0_CTL + `CHAN_STRIDE + 8'h02) begin
				o_rd_data <= val_all[23:16];
			end else begin
				o_rd_data <= 8'h00;
			end
		end
	end

endmodule // timer_pwm_channels

`default_nettype wire

/* hw/timer_pwm_consts.vh */
// register map, field positions, reset values and prescaler codes of the two-channel pwm timer
// assumes an 8-bit register port with the printed byte offsets as addresses
`ifndef TIMER_PWM_CONSTS_VH
`define TIMER_PWM_CONSTS_VH

`define A_TIMER_CTL     8'h20
`define A_COUNT_HIGH    8'h21
`define A_COUNT_LOW     8'h22
`define A_PERIOD_HIGH   8'h23
`define A_PERIOD_LOW    8'h24
`define A_CHAN0_CTL     8'h25
`define CHAN_STRIDE     8'h03

`define TC_WRAP_FLAG    7
`define TC_WRAP_IE      6
`define TC_HALT         5
`define TC_CLEAR        4
`define TC_DIV_HI       2
`define TC_DIV_LO       0

`define CC_EVENT_FLAG   7
`define CC_IRQ_EN       6
`define CC_BUF_SEL      5
`define CC_FUNC_SEL     4
`define CC_ACT_HI       3
`define CC_ACT_LO       2
`define CC_TOGGLE_WRAP  1
`define CC_FULL_DUTY    0

`define RST_TIMER_CTL   8'h20
`define RST_PERIOD      16'hFFFF
`define RST_CHAN_CTL    8'h00
`define RST_CHAN_VALUE  16'h0000

`define DIV_NONE        3'h7
`define ACT_TOGGLE      2'h1
`define ACT_CLEAR       2'h2
`define ACT_SET         2'h3

`endif

/* dv/pwm_timer_chk_sva.sv */
// checker on the timer ports: bus answers, irq masking, pin hold in halt and stop
// assumes bound into the timer top; control bits tracked from the write strobes
`timescale 1ns/1ns
`default_nettype none
module pwm_timer_chk (
	input wire logic       i_clk,
	input wire logic       i_sys_rst,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wr_data,
	input wire logic       i_wr,
	input wire logic       i_rd,
	input wire logic       i_wait_mode,
	input wire logic       i_stop_mode,
	input wire logic [7:0] o_rd_data,
	input wire logic       o_chan0_pin,
	input wire logic       o_chan0_oe,
	input wire logic       o_chan1_oe,
	input wire logic       o_irq
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	logic       take;
	logic [2:0] ie_q;
	logic       buf_q;
	logic       halt_q;
	logic [1:0] quiet_q;
	assign take = i_wr && !i_wait_mode;
	// pins lag writes by two cycles, so holds are judged only after a quiet spell
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			ie_q    <= 3'h0;
			buf_q   <= 1'b0;
			halt_q  <= 1'b1;
			quiet_q <= 2'h0;
		end else begin
			quiet_q <= take ? 2'h0 : (quiet_q == 2'h3 ? 2'h3 : quiet_q + 2'h1);
			if (take && i_addr == 8'h20) begin
				ie_q[0] <= i_wr_data[6];
				halt_q  <= i_wr_data[5];
			end
			if (take && i_addr == 8'h25) begin
				ie_q[1] <= i_wr_data[6];
				buf_q   <= i_wr_data[5];
			end
			if (take && i_addr == 8'h28)
				ie_q[2] <= i_wr_data[6];
		end
	end
	chk_reset_vals: assert property ($past(i_sys_rst) |-> !o_irq && !o_chan0_oe && o_chan0_pin && o_rd_data == 8'h00)
		else $error("outputs off reset level");
	chk_rd_idle: assert property (!$past(i_rd) |-> o_rd_data == 8'h00)
		else $error("read data without read");
	chk_wait_block: assert property ($past(i_rd) && $past(i_wait_mode) |-> o_rd_data == 8'h00)
		else $error("read answered in wait");
	chk_clear_reads0: assert property ($past(i_rd) && $past(i_addr) == 8'h20 |-> !o_rd_data[4])
		else $error("clear bit read as one");
	chk_irq_masked: assert property (ie_q == 3'h0 && $past(ie_q) == 3'h0 && $past(ie_q, 2) == 3'h0 |-> !o_irq)
		else $error("irq with all enables off");
	chk_ch1_free: assert property (buf_q && $past(buf_q, 2) |-> !o_chan1_oe)
		else $error("ch1 driven in buffered mode");
	chk_halt_freeze: assert property (halt_q && quiet_q == 2'h3 |-> $stable(o_chan0_pin) && $stable(o_chan0_oe))
		else $error("pin moved while halted");
	chk_stop_hold: assert property (i_stop_mode && $past(i_stop_mode, 3) && quiet_q == 2'h3 |-> $stable(o_chan0_pin))
		else $error("pin moved in stop");
	cover property ($rose(o_irq));
	cover property ($rose(o_chan0_pin) && buf_q);
	cover property (i_stop_mode && quiet_q == 2'h3);
endmodule // pwm_timer_chk
bind timer_pwm_channels pwm_timer_chk u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
	.i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .i_wait_mode(i_wait_mode), .i_stop_mode(i_stop_mode),
	.o_rd_data(o_rd_data), .o_chan0_pin(o_chan0_pin), .o_chan0_oe(o_chan0_oe), .o_chan1_oe(o_chan1_oe),
	.o_irq(o_irq));
`default_nettype wire

/* dv/pwm_load_model.sv */
// load on a timer pin: shows the line level and measures rise-to-rise period
// assumes one clock; the line has no pull, so undriven it wanders
`timescale 1ns/1ns
`default_nettype none
module pwm_load_model (
	input  wire logic i_clk,
	input  wire logic i_pin,
	input  wire logic i_oe,
	output wire logic o_level,
	output var  int   o_period
);
	logic last_q = 1'b0;
	int   cnt    = 0;
	// never a stale copy once released: the simulator would settle it kindly
	assign o_level = i_oe ? i_pin : ~last_q;
	initial o_period = 0;
	always @(posedge i_clk) begin
		last_q <= o_level;
		cnt    <= (o_level && !last_q) ? 1 : cnt + 1;
		if (o_level && !last_q)
			o_period <= cnt;
	end
endmodule // pwm_load_model
`default_nettype wire

/* dv/tb.sv */
// self-checking bench for the two-channel pwm timer
// assumes checker and load model compiled first
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic       clk = 0, rst = 1, wr = 0, rd = 0, wt = 0, sp = 0;
	logic [7:0] addr = 0, wdat = 0, rdat, got;
	logic       p0, p1, oe0, oe1, irq, lv0, lv1;
	int         per0, n_fail = 0, n_compared = 0, seed = 32'he993, P = 9, W = 3, k, hi, t;
	initial forever #25 clk = ~clk;
	timer_pwm_channels DUT (.i_clk(clk), .i_sys_rst(rst), .i_addr(addr), .i_wr_data(wdat), .i_wr(wr),
		.i_rd(rd), .i_wait_mode(wt), .i_stop_mode(sp), .i_chan0_pin(lv0), .i_chan1_pin(lv1), .o_rd_data(rdat),
		.o_chan0_pin(p0), .o_chan0_oe(oe0), .o_chan1_pin(p1), .o_chan1_oe(oe1), .o_irq(irq));
	pwm_load_model L0 (.i_clk(clk), .i_pin(p0), .i_oe(oe0), .o_level(lv0), .o_period(per0));
	pwm_load_model L1 (.i_clk(clk), .i_pin(p1), .i_oe(oe1), .o_level(lv1), .o_period());
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask
	task automatic print_verdict;
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic wrr(input logic [7:0] a, d);
		@(posedge clk);
		wr   <= 1;
		addr <= a;
		wdat <= d;
		@(posedge clk);
		wr <= 0;
	endtask
	task automatic rdv(input logic [7:0] a);
		@(posedge clk);
		rd   <= 1;
		addr <= a;
		@(posedge clk);
		rd <= 0;
		@(negedge clk);
		got = rdat;
	endtask
	task automatic rdc(input logic [7:0] a, e, input string nm);
		rdv(a);
		chk(nm, got, e);
	endtask
	// high cycles over n cycles; one whole period gives the pulse width
	task automatic duty(input int n);
		repeat (2 * n) @(posedge clk);
		hi = 0;
		repeat (n) begin
			@(negedge clk);
			hi += lv0;
		end
	endtask
	task automatic setup(input logic [7:0] ctl, input int kk);
		wrr(8'h20, 8'h30);
		rdc(8'h21, 8'h00, "count_hi");
		rdc(8'h22, 8'h00, "count_lo");
		wrr(8'h23, 8'h00);
		wrr(8'h24, P[7:0]);
		wrr(8'h26, 8'h00);
		wrr(8'h27, W[7:0]);
		wrr(8'h25, ctl);
		wrr(8'h20, kk[7:0]);
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst <= 0;
		rdc(8'h20, 8'h20, "ctl_reset");
		rdc(8'h24, 8'hFF, "period_reset");
		rdc(8'h30, 8'h00, "unmapped");
		$display("registers done");
		for (k = 0; k < 7; k++) begin
			P = 8 + ($random(seed) & 15);
			W = 1 + ($random(seed) & 255) % (P - 1);
			setup(8'h1A, k);
			duty((P + 1) << k);
			chk("pwm_high", hi, (W + 1) << k);
			chk("pwm_period", per0, (P + 1) << k);
			$display("divider %0d done", k);
		end
		rdc(8'h20, 8'h86, "wrap_flag");
		wrr(8'h20, 8'h46);
		t = 0;
		while (irq !== 1'b1 && t < 3000) begin
			@(negedge clk);
			t++;
		end
		chk("irq_raised", t < 3000, 1);
		if (t >= 3000)
			print_verdict;
		wrr(8'h20, 8'h06);
		repeat (3) @(negedge clk);
		chk("irq_masked", irq, 1'b0);
		$display("irq done");
		wrr(8'h20, 8'h30);
		rdv(8'h25);
		wrr(8'h25, 8'h18);
		rdc(8'h25, 8'h18, "ch0_flag_clr");
		setup(8'h18, 0);
		duty(P + 1);
		chk("zero_duty", hi, 0);
		rdc(8'h25, 8'h98, "ch0_flag");
		wrr(8'h25, 8'h1B);
		duty(P + 1);
		chk("full_duty", hi, P + 1);
		wrr(8'h29, 8'h00);
		wrr(8'h2A, 8'h03);
		W = 6;
		setup(8'h2A, 0);
		duty(P + 1);
		chk("buf_ch0", hi, W + 1);
		wrr(8'h2A, 8'h04);
		duty(P + 1);
		chk("buf_ch1", hi, 5);
		chk("ch1_free", oe1, 1'b0);
		$display("duty and buffered done");
		@(posedge clk);
		sp <= 1;
		rdv(8'h22);
		t = got;
		repeat (40) @(posedge clk);
		rdv(8'h22);
		chk("stop_hold", got, t);
		@(posedge clk);
		sp <= 0;
		wt <= 1;
		rdc(8'h20, 8'h00, "wait_read");
		@(posedge clk);
		wt <= 0;
		$display("low power done");
		@(posedge clk);
		rst <= 1;
		repeat (2) @(posedge clk);
		rst <= 0;
		rdc(8'h20, 8'h20, "ctl_rerst");
		rdc(8'h24, 8'hFF, "period_rerst");
		$display("second reset done");
		print_verdict;
	end
endmodule // tb
`default_nettype wire
